// ==== rtl/dup_device.sv ====
// Dual serial channel device with its parallel host port
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module dup_device (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// Host bus
	dup_if.device           bus_if,
	// Serial pins
	input  wire logic       i_chan0_ser_in,
	input  wire logic       i_chan1_ser_in,
	output logic            o_chan0_ser_out,
	output logic            o_chan1_ser_out,
	// Interrupt and general outputs
	output logic            o_chan0_irq,
	output logic            o_chan0_irq_oe,
	output logic            o_chan1_irq,
	output logic            o_chan1_irq_oe,
	output logic            o_chan0_gp_out_n,
	output logic            o_chan1_gp_out_n,
	// Modem status inputs, per channel
	input  wire logic [1:0] i_clear_to_send_n,
	input  wire logic [1:0] i_set_ready_n,
	input  wire logic [1:0] i_carrier_in_n,
	input  wire logic [1:0] i_ring_in_n
);
	typedef struct packed {
		logic [15:0] div;
		logic [7:0]  line;
		logic [7:0]  modem;
		logic [7:0]  scratch;
		logic [7:0]  thr;
		logic        thr_full;
		logic [10:0] tx_sh;
		logic [3:0]  tx_left;
		logic [15:0] tx_cnt;
		logic [10:0] rx_sh;
		logic [3:0]  rx_idx;
		logic        rx_busy;
		logic [15:0] rx_cnt;
		logic [7:0]  rhr;
		logic [2:0]  rx_tag;
		logic        rx_ready;
		logic        ser_out;
		logic        irq;
		logic        irq_oe;
		logic        gp_n;
	} dup_chan_t;

	typedef struct packed {
		dup_chan_t [1:0] ch;
		logic            rd_prev;
		logic            wr_prev;
		logic [7:0]      dout;
		logic            dout_oe;
	} dup_dev_t;

	dup_dev_t r_q;
	dup_dev_t r_d;

	localparam int LINE_LEN_LO  = dup_pkg::LINE_LEN_LO;
	localparam int MODEM_GP_I   = dup_pkg::MODEM_GP;
	localparam int MODEM_LOOP_I = dup_pkg::MODEM_LOOP;

	function automatic logic [3:0] data_bits(input logic [7:0] line);
		data_bits = 4'd5 + {2'b00, line[LINE_LEN_LO +: 2]};
	endfunction

	// Start + data + optional parity + one stop
	function automatic logic [3:0] frame_len(input logic [7:0] line);
		frame_len = data_bits(line) + 4'd2 + {3'b000, line[dup_pkg::LINE_PAR_EN]};
	endfunction

	function automatic logic [7:0] mask_data(input logic [7:0] d, input logic [7:0] line);
		mask_data = d & (8'hff >> (4'd8 - data_bits(line)));
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line);
		par_bit = (^mask_data(d, line)) ^ ~line[dup_pkg::LINE_PAR_EVEN];
	endfunction

	// Unused upper positions are stop level
	function automatic logic [10:0] build_frame(input logic [7:0] d, input logic [7:0] line);
		logic [10:0] f;
		f = {2'b11, 8'hff, 1'b0};
		for (int i = 0; i < 8; i++)
		begin
			if (4'(i) < data_bits(line))
				f[i + 1] = d[i];
		end
		if (line[dup_pkg::LINE_PAR_EN])
			f[data_bits(line) + 4'd1] = par_bit(d, line);
		build_frame = f;
	endfunction

	function automatic logic [15:0] div_eff(input logic [15:0] div);
		div_eff = (div == 16'h0000) ? 16'h0001 : div;
	endfunction

	always_comb
	begin
		logic [1:0]  sel;
		logic        rd_n;
		logic        wr_n;
		logic        rd_fall;
		logic        rd_rise;
		logic        wr_rise;
		logic        tx_line;
		logic        rx_in;
		logic [10:0] sh;
		logic [7:0]  rdata;
		logic [7:0]  dbyte;
		logic [15:0] dv;
		logic [7:0]  ln;
		sel     = {~bus_if.chan1_sel_n, ~bus_if.chan0_sel_n};
		rd_n    = bus_if.rd_strobe_n;
		wr_n    = bus_if.wr_strobe_n;
		rd_fall = r_q.rd_prev & ~rd_n;
		rd_rise = ~r_q.rd_prev & rd_n;
		wr_rise = ~r_q.wr_prev & wr_n;
		tx_line = 1'b1;
		rx_in   = 1'b1;
		sh      = 11'h000;
		rdata   = 8'h00;
		dbyte   = 8'h00;
		dv      = 16'h0000;
		ln      = 8'h00;
		r_d     = r_q;
		r_d.rd_prev = rd_n;
		r_d.wr_prev = wr_n;
		// Bus released on strobe rise or loss of select
		if (rd_rise || sel == 2'b00)
			r_d.dout_oe = 1'b0;

		for (int c = 0; c < 2; c++)
		begin
			dv = div_eff(r_q.ch[c].div);
			ln = r_q.ch[c].line;
			// Host access for this channel
			if (sel[c] && rd_fall)
			begin
				case (bus_if.reg_sel)
					dup_pkg::REG_DATA:    rdata = r_q.ch[c].rhr;
					dup_pkg::REG_DIV_LO:  rdata = r_q.ch[c].div[7:0];
					dup_pkg::REG_DIV_HI:  rdata = r_q.ch[c].div[15:8];
					dup_pkg::REG_LINE:    rdata = ln;
					dup_pkg::REG_MODEM:   rdata = r_q.ch[c].modem;
					dup_pkg::REG_STATUS:
					begin
						rdata = 8'h00;
						rdata[dup_pkg::STAT_RX_RDY]    = r_q.ch[c].rx_ready;
						rdata[dup_pkg::STAT_OVERRUN +: 3] = r_q.ch[c].rx_tag;
						rdata[dup_pkg::STAT_THR_EMPTY] = ~r_q.ch[c].thr_full;
						rdata[dup_pkg::STAT_TX_IDLE]   =
							~r_q.ch[c].thr_full && r_q.ch[c].tx_left == 4'h0;
					end
					// Read only; never steers the data path
					dup_pkg::REG_MSTAT:   rdata = {4'h0, ~i_carrier_in_n[c],
						~i_ring_in_n[c], ~i_set_ready_n[c], ~i_clear_to_send_n[c]};
					dup_pkg::REG_SCRATCH: rdata = r_q.ch[c].scratch;
					default:              rdata = 8'h00;
				endcase
				r_d.dout    = rdata;
				r_d.dout_oe = 1'b1;
			end
			// Receive data consumed at end of its read
			if (sel[c] && rd_rise && bus_if.reg_sel == dup_pkg::REG_DATA)
			begin
				r_d.ch[c].rx_ready = 1'b0;
				r_d.ch[c].rx_tag   = 3'b000;
			end
			if (sel[c] && wr_rise)
			begin
				case (bus_if.reg_sel)
					dup_pkg::REG_DATA:
					begin
						// A full stage is overwritten: only one byte deep
						r_d.ch[c].thr      = bus_if.bus;
						r_d.ch[c].thr_full = 1'b1;
					end
					dup_pkg::REG_DIV_LO:  r_d.ch[c].div[7:0]  = bus_if.bus;
					dup_pkg::REG_DIV_HI:  r_d.ch[c].div[15:8] = bus_if.bus;
					dup_pkg::REG_LINE:    r_d.ch[c].line      = bus_if.bus;
					dup_pkg::REG_MODEM:   r_d.ch[c].modem     = bus_if.bus;
					dup_pkg::REG_SCRATCH: r_d.ch[c].scratch   = bus_if.bus;
					default:              r_d.ch[c].scratch   = r_q.ch[c].scratch;
				endcase
			end

			// Transmitter
			tx_line = (r_q.ch[c].tx_left != 4'h0) ? r_q.ch[c].tx_sh[0] : 1'b1;
			if (r_q.ch[c].tx_left == 4'h0)
			begin
				if (r_q.ch[c].thr_full && !(sel[c] && wr_rise &&
					bus_if.reg_sel == dup_pkg::REG_DATA))
				begin
					r_d.ch[c].tx_sh    = build_frame(r_q.ch[c].thr, ln);
					r_d.ch[c].tx_left  = frame_len(ln);
					r_d.ch[c].tx_cnt   = dv - 16'h0001;
					r_d.ch[c].thr_full = 1'b0;
				end
			end
			else if (r_q.ch[c].tx_cnt == 16'h0000)
			begin
				r_d.ch[c].tx_sh   = {1'b1, r_q.ch[c].tx_sh[10:1]};
				r_d.ch[c].tx_left = r_q.ch[c].tx_left - 4'h1;
				r_d.ch[c].tx_cnt  = dv - 16'h0001;
			end
			else
				r_d.ch[c].tx_cnt = r_q.ch[c].tx_cnt - 16'h0001;
			// Pin held at idle while looped back
			r_d.ch[c].ser_out = (r_d.ch[c].tx_left != 4'h0 && !r_q.ch[c].modem[MODEM_LOOP_I])
				? r_d.ch[c].tx_sh[0] : 1'b1;

			// Receiver; relies on an idle-high line between characters
			rx_in = r_q.ch[c].modem[MODEM_LOOP_I] ? tx_line
				: (c == 0 ? i_chan0_ser_in : i_chan1_ser_in);
			if (!r_q.ch[c].rx_busy)
			begin
				if (!rx_in)
				begin
					r_d.ch[c].rx_busy = 1'b1;
					r_d.ch[c].rx_idx  = 4'h0;
					r_d.ch[c].rx_cnt  = dv >> 1;
				end
			end
			else if (r_q.ch[c].rx_cnt == 16'h0000)
			begin
				sh = r_q.ch[c].rx_sh;
				sh[r_q.ch[c].rx_idx] = rx_in;
				r_d.ch[c].rx_sh  = sh;
				r_d.ch[c].rx_cnt = dv - 16'h0001;
				r_d.ch[c].rx_idx = r_q.ch[c].rx_idx + 4'h1;
				if (r_q.ch[c].rx_idx == 4'h0 && rx_in)
					r_d.ch[c].rx_busy = 1'b0;
				else if (r_q.ch[c].rx_idx == frame_len(ln) - 4'h1)
				begin
					// A new byte wins over a read clearing the old one
					dbyte = mask_data(sh[8:1], ln);
					r_d.ch[c].rx_busy  = 1'b0;
					r_d.ch[c].rhr      = dbyte;
					r_d.ch[c].rx_tag   = {~rx_in,
						ln[dup_pkg::LINE_PAR_EN] &&
						(sh[data_bits(ln) + 4'd1] != par_bit(dbyte, ln)),
						r_q.ch[c].rx_ready && !(sel[c] && rd_rise &&
						bus_if.reg_sel == dup_pkg::REG_DATA)};
					r_d.ch[c].rx_ready = 1'b1;
				end
			end
			else
				r_d.ch[c].rx_cnt = r_q.ch[c].rx_cnt - 16'h0001;

			// Interrupt drive and general output share the modem bit
			r_d.ch[c].irq    = r_d.ch[c].rx_ready;
			r_d.ch[c].irq_oe = r_d.ch[c].modem[MODEM_GP_I];
			r_d.ch[c].gp_n   = ~r_d.ch[c].modem[MODEM_GP_I];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			r_q         <= '0;
			r_q.rd_prev <= 1'b1;
			r_q.wr_prev <= 1'b1;
			for (int c = 0; c < 2; c++)
			begin
				r_q.ch[c].div     <= dup_pkg::DIV_RST;
				r_q.ch[c].line    <= dup_pkg::LINE_RST;
				r_q.ch[c].modem   <= dup_pkg::MODEM_RST;
				r_q.ch[c].ser_out <= 1'b1;
				r_q.ch[c].gp_n    <= 1'b1;
			end
		end
		else
			r_q <= r_d;
	end

	assign bus_if.dev_d     = r_q.dout;
	assign bus_if.dev_oe    = r_q.dout_oe;
	assign o_chan0_ser_out  = r_q.ch[0].ser_out;
	assign o_chan1_ser_out  = r_q.ch[1].ser_out;
	assign o_chan0_irq      = r_q.ch[0].irq;
	assign o_chan0_irq_oe   = r_q.ch[0].irq_oe;
	assign o_chan1_irq      = r_q.ch[1].irq;
	assign o_chan1_irq_oe   = r_q.ch[1].irq_oe;
	assign o_chan0_gp_out_n = r_q.ch[0].gp_n;
	assign o_chan1_gp_out_n = r_q.ch[1].gp_n;
endmodule

// ==== rtl/dup_pkg.sv ====
// Shared constants for the dual serial channel host port
package dup_pkg;
	// Clock
	localparam int CLK_NS = 4;
	localparam int CLK_HZ = 250_000_000;
	localparam int MAX_BPS = 1_500_000;

	// Register selects within one channel
	localparam logic [2:0] REG_DATA    = 3'h0;
	localparam logic [2:0] REG_DIV_LO  = 3'h1;
	localparam logic [2:0] REG_DIV_HI  = 3'h2;
	localparam logic [2:0] REG_LINE    = 3'h3;
	localparam logic [2:0] REG_MODEM   = 3'h4;
	localparam logic [2:0] REG_STATUS  = 3'h5;
	localparam logic [2:0] REG_MSTAT   = 3'h6;
	localparam logic [2:0] REG_SCRATCH = 3'h7;

	// Line control fields
	localparam int LINE_LEN_LO   = 0;
	localparam int LINE_PAR_EN   = 3;
	localparam int LINE_PAR_EVEN = 4;
	// Modem control fields
	localparam int MODEM_GP   = 3;
	localparam int MODEM_LOOP = 4;
	// Line status fields
	localparam int STAT_RX_RDY    = 0;
	localparam int STAT_OVERRUN   = 1;
	localparam int STAT_PAR_ERR   = 2;
	localparam int STAT_FRAME_ERR = 3;
	localparam int STAT_THR_EMPTY = 5;
	localparam int STAT_TX_IDLE   = 6;

	// Reset values
	localparam logic [7:0]  LINE_RST  = 8'h03;
	localparam logic [7:0]  MODEM_RST = 8'h00;
	localparam int          DIV_RST_I = CLK_HZ / MAX_BPS;
	localparam logic [15:0] DIV_RST   = 16'(DIV_RST_I);

	// Host strobe timing, least times rounded up
	localparam int SETUP_NS   = 8;
	localparam int STROBE_NS  = 40;
	localparam int HOLD_NS    = 8;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;

	// Host controller register map on APB
	localparam logic [11:0] APB_CMD    = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam int CMD_SEL_LO  = 0;
	localparam int CMD_CHAN    = 3;
	localparam int CMD_READ    = 4;
	localparam int CMD_DATA_LO = 8;
	localparam int STS_BUSY    = 0;
	localparam int STS_DATA_LO = 8;
endpackage

// ==== rtl/dup_if.sv ====
// Parallel host bus between the host controller and the serial device
`timescale 1ns/1ns
interface dup_if;
	logic [2:0] reg_sel;
	logic       rd_strobe_n;
	logic       wr_strobe_n;
	logic       chan0_sel_n;
	logic       chan1_sel_n;
	logic [7:0] host_d;
	logic       host_oe;
	logic [7:0] dev_d;
	logic       dev_oe;
	logic [7:0] bus;

	// Resolved data bus; an undriven bus reads as pulled high
	assign bus = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);

	modport device (
		input  reg_sel, rd_strobe_n, wr_strobe_n, chan0_sel_n, chan1_sel_n, bus,
		output dev_d, dev_oe
	);
	modport host (
		input  bus,
		output reg_sel, rd_strobe_n, wr_strobe_n, chan0_sel_n, chan1_sel_n,
		output host_d, host_oe
	);
endinterface

// ==== rtl/dup_host.sv ====
// Host controller: APB registers in, strobed parallel bus cycles out
`timescale 1ns/1ns
module dup_host (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Device bus
	dup_if.host              bus_if
);
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} dup_hstate_t;

	typedef struct packed {
		dup_hstate_t state;
		logic [7:0]  cnt;
		logic [15:0] cmd;
		logic        is_rd;
		logic [2:0]  reg_sel;
		logic        sel0_n;
		logic        sel1_n;
		logic        rd_n;
		logic        wr_n;
		logic [7:0]  hd;
		logic        hoe;
		logic [7:0]  rdata;
		logic        busy;
		logic [31:0] prdata;
		logic        pready;
	} dup_host_t;

	dup_host_t r_q;
	dup_host_t r_d;

	always_comb
	begin
		logic [31:0] rd;
		rd  = 32'h0000_0000;
		r_d = r_q;
		// Answer in the access phase after setup; no wait states
		r_d.pready = i_psel && !i_penable;
		if (i_psel && !i_penable)
		begin
			if (i_paddr == dup_pkg::APB_CMD)
				rd = {16'h0000, r_q.cmd};
			else if (i_paddr == dup_pkg::APB_STATUS)
			begin
				rd[dup_pkg::STS_BUSY] = r_q.busy;
				rd[dup_pkg::STS_DATA_LO +: 8] = r_q.rdata;
			end
			r_d.prdata = rd;
		end
		case (r_q.state)
			ST_IDLE:
			begin
				// Commands are ignored while a bus cycle is running
				if (i_psel && i_penable && r_q.pready && i_pwrite &&
					i_paddr == dup_pkg::APB_CMD)
				begin
					r_d.cmd     = i_pwdata[15:0];
					r_d.reg_sel = i_pwdata[dup_pkg::CMD_SEL_LO +: 3];
					r_d.is_rd   = i_pwdata[dup_pkg::CMD_READ];
					r_d.hd      = i_pwdata[dup_pkg::CMD_DATA_LO +: 8];
					r_d.hoe     = ~i_pwdata[dup_pkg::CMD_READ];
					r_d.sel0_n  = i_pwdata[dup_pkg::CMD_CHAN];
					r_d.sel1_n  = ~i_pwdata[dup_pkg::CMD_CHAN];
					r_d.busy    = 1'b1;
					r_d.cnt     = 8'(dup_pkg::SETUP_CYC - 1);
					r_d.state   = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				if (r_q.cnt == 8'h00)
				begin
					r_d.rd_n  = ~r_q.is_rd;
					r_d.wr_n  = r_q.is_rd;
					r_d.cnt   = 8'(dup_pkg::STROBE_CYC - 1);
					r_d.state = ST_STROBE;
				end
				else
					r_d.cnt = r_q.cnt - 8'h01;
			end
			ST_STROBE:
			begin
				if (r_q.cnt == 8'h00)
				begin
					// Data still driven and held across the strobe rise
					r_d.rd_n = 1'b1;
					r_d.wr_n = 1'b1;
					if (r_q.is_rd)
						r_d.rdata = bus_if.bus;
					r_d.cnt   = 8'(dup_pkg::HOLD_CYC - 1);
					r_d.state = ST_HOLD;
				end
				else
					r_d.cnt = r_q.cnt - 8'h01;
			end
			ST_HOLD:
			begin
				if (r_q.cnt == 8'h00)
				begin
					r_d.sel0_n = 1'b1;
					r_d.sel1_n = 1'b1;
					r_d.hoe    = 1'b0;
					r_d.busy   = 1'b0;
					r_d.state  = ST_IDLE;
				end
				else
					r_d.cnt = r_q.cnt - 8'h01;
			end
			default: r_d.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			r_q        <= '0;
			r_q.state  <= ST_IDLE;
			r_q.sel0_n <= 1'b1;
			r_q.sel1_n <= 1'b1;
			r_q.rd_n   <= 1'b1;
			r_q.wr_n   <= 1'b1;
		end
		else
			r_q <= r_d;
	end

	assign o_prdata           = r_q.prdata;
	assign o_pready           = r_q.pready;
	assign o_pslverr          = 1'b0;
	assign bus_if.reg_sel     = r_q.reg_sel;
	assign bus_if.chan0_sel_n = r_q.sel0_n;
	assign bus_if.chan1_sel_n = r_q.sel1_n;
	assign bus_if.rd_strobe_n = r_q.rd_n;
	assign bus_if.wr_strobe_n = r_q.wr_n;
	assign bus_if.host_d      = r_q.hd;
	assign bus_if.host_oe     = r_q.hoe;
endmodule

// ==== bench/dup_assertions.sv ====
// Bus timing and pin checks between the host controller and the device
`timescale 1ns/1ns
module dup_assertions (
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_srst,
	// Host bus
	input wire logic [2:0] reg_sel,
	input wire logic       rd_strobe_n,
	input wire logic       wr_strobe_n,
	input wire logic       chan0_sel_n,
	input wire logic       chan1_sel_n,
	input wire logic [7:0] host_d,
	input wire logic       host_oe,
	input wire logic       dev_oe,
	// Device pins
	input wire logic       o_chan0_gp_out_n,
	input wire logic       o_chan0_irq_oe,
	input wire logic       o_chan1_gp_out_n,
	input wire logic       o_chan1_irq_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_rd_drive;
		(!rd_strobe_n && !(chan0_sel_n && chan1_sel_n)) [*2] |-> dev_oe;
	endproperty
	property p_rd_end;
		dev_oe |-> !$past(rd_strobe_n) || !$past(rd_strobe_n, 2);
	endproperty
	property p_release;
		(chan0_sel_n && chan1_sel_n) [*2] |-> !dev_oe;
	endproperty
	property p_no_clash;
		!(dev_oe && host_oe) && !(dev_oe && !wr_strobe_n);
	endproperty
	// Strobe width fixed by the controller at ten cycles, exactly the rounded-up 40 ns device minimum
	property p_wr_width;
		$fell(wr_strobe_n) |-> !wr_strobe_n [*8] ##1 !wr_strobe_n [*2] ##1 wr_strobe_n;
	endproperty
	property p_wr_hold;
		(!wr_strobe_n || $rose(wr_strobe_n)) |-> host_oe && $stable(host_d);
	endproperty
	property p_sel_setup;
		($fell(rd_strobe_n) || $fell(wr_strobe_n)) |-> !$past(chan0_sel_n && chan1_sel_n, 2);
	endproperty
	property p_one_sel;
		(!rd_strobe_n || !wr_strobe_n) |-> (chan0_sel_n ^ chan1_sel_n) && $stable(reg_sel);
	endproperty
	property p_gp0;
		o_chan0_gp_out_n == !o_chan0_irq_oe;
	endproperty
	property p_gp1;
		o_chan1_gp_out_n == !o_chan1_irq_oe;
	endproperty

	a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
	a_rd_end: assert property (p_rd_end) else $error("bus driven after read");
	a_release: assert property (p_release) else $error("bus driven unselected");
	a_no_clash: assert property (p_no_clash) else $error("bus contention");
	a_wr_width: assert property (p_wr_width) else $error("write strobe width");
	a_wr_hold: assert property (p_wr_hold) else $error("write data unstable");
	a_sel_setup: assert property (p_sel_setup) else $error("select setup");
	a_one_sel: assert property (p_one_sel) else $error("select or address");
	a_gp0: assert property (p_gp0) else $error("chan0 gp and irq");
	a_gp1: assert property (p_gp1) else $error("chan1 gp and irq");

	c_rd0: cover property ($fell(rd_strobe_n) && !chan0_sel_n);
	c_rd1: cover property ($fell(rd_strobe_n) && !chan1_sel_n);
	c_wr: cover property ($rose(wr_strobe_n));
endmodule

// ==== bench/dup_tb.sv ====
// Self-checking bench: APB controller driving the dual serial device
`timescale 1ns/1ns
module dup_tb;
	localparam logic [7:0] DIV = 8'h08;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ser0, ser1, irq0, irq1, oe0, oe1, gp0, gp1;
	logic [1:0]  cts_n = 2'b11;
	logic [1:0]  dsr_n = 2'b11;
	logic [1:0]  cd_n = 2'b11;
	logic [1:0]  ri_n = 2'b11;
	int          error_cnt = 0;
	int          num_checks = 0;

	dup_if bus_if ();
	dup_host dup_host_inst (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .bus_if(bus_if.host));
	// Channels cross-wired so each one's transmitter feeds the other's receiver
	dup_device dup_device_inst (.i_clk(clk), .i_srst(srst), .bus_if(bus_if.device),
		.i_chan0_ser_in(ser1), .i_chan1_ser_in(ser0), .o_chan0_ser_out(ser0),
		.o_chan1_ser_out(ser1), .o_chan0_irq(irq0), .o_chan0_irq_oe(oe0), .o_chan1_irq(irq1),
		.o_chan1_irq_oe(oe1), .o_chan0_gp_out_n(gp0), .o_chan1_gp_out_n(gp1),
		.i_clear_to_send_n(cts_n), .i_set_ready_n(dsr_n), .i_carrier_in_n(cd_n),
		.i_ring_in_n(ri_n));
	dup_assertions dup_assertions_inst (.i_clk(clk), .i_srst(srst), .reg_sel(bus_if.reg_sel),
		.rd_strobe_n(bus_if.rd_strobe_n), .wr_strobe_n(bus_if.wr_strobe_n),
		.chan0_sel_n(bus_if.chan0_sel_n), .chan1_sel_n(bus_if.chan1_sel_n),
		.host_d(bus_if.host_d), .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe),
		.o_chan0_gp_out_n(gp0), .o_chan0_irq_oe(oe0), .o_chan1_gp_out_n(gp1),
		.o_chan1_irq_oe(oe1));

	initial
	begin
		forever #(dup_pkg::CLK_NS / 2) clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang;
		error_cnt++;
		$display("[FAIL] wait expected done seen timeout");
		end_of_test();
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One host bus cycle; returns the byte read
	task automatic cmd(input logic c, input logic [2:0] r, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] v;
		int          n;
		apb(1'b1, dup_pkg::APB_CMD, {16'h0, d, 3'h0, rd, c, r}, v);
		n = 0;
		do
		begin
			apb(1'b0, dup_pkg::APB_STATUS, 32'h0, v);
			n++;
		end
		while (v[dup_pkg::STS_BUSY] !== 1'b0 && n < 40);
		if (n >= 40)
			hang();
		q = v[15:8];
	endtask

	task automatic wr(input logic c, input logic [2:0] r, input logic [7:0] d);
		logic [7:0] q;
		cmd(c, r, 1'b0, d, q);
	endtask

	task automatic rd_chk(input string what, input logic c, input logic [2:0] r,
		input logic [7:0] exp);
		logic [7:0] q;
		cmd(c, r, 1'b1, 8'h00, q);
		check(what, q, exp);
	endtask

	task automatic wait_rx(input logic c);
		logic [7:0] q;
		int         n;
		n = 0;
		do
		begin
			cmd(c, dup_pkg::REG_STATUS, 1'b1, 8'h00, q);
			n++;
		end
		while (q[dup_pkg::STAT_RX_RDY] !== 1'b1 && n < 60);
		if (n >= 60)
			hang();
	endtask

	// Start bit width in cycles, then ten bits after it taken mid-bit
	task automatic grab(input logic c, output int t, output logic [9:0] f);
		int n;
		n = 0;
		t = 0;
		f = 10'h000;
		while ((c ? ser1 : ser0) !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		while ((c ? ser1 : ser0) === 1'b0 && t < 200)
		begin
			@(posedge clk);
			t++;
		end
		repeat (DIV / 2) @(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			f[i] = c ? ser1 : ser0;
			repeat (DIV) @(posedge clk);
		end
	endtask

	function automatic logic [7:0] mask(input logic [7:0] b, input int len);
		return b & 8'((9'h1 << len) - 1);
	endfunction

	// Bits after the start bit: data LSB first, parity, then stop level
	function automatic logic [9:0] frame(input logic [7:0] b, input int len, input int p);
		logic [7:0] m;
		logic [9:0] f;
		m = mask(b, len);
		f = 10'h3ff;
		for (int i = 0; i < len; i++)
			f[i] = m[i];
		if (p != 0)
			f[len] = (^m) ^ (p == 1);
		return f;
	endfunction

	task automatic xfer(input logic s, input int len, input int p, input logic [7:0] b);
		int         t;
		logic [9:0] f;
		fork
			wr(s, dup_pkg::REG_DATA, b);
			grab(s, t, f);
		join
		check("bit time", 32'(t), 32'(DIV));
		check("frame", 32'(f), 32'(frame(b, len, p)));
		wait_rx(!s);
		check("irq set", s ? irq0 : irq1, 1'b1);
		rd_chk("rx status", !s, dup_pkg::REG_STATUS, 8'h61);
		rd_chk("rx data", !s, dup_pkg::REG_DATA, mask(b, len));
		check("irq clr", s ? irq0 : irq1, 1'b0);
		rd_chk("rx cleared", !s, dup_pkg::REG_STATUS, 8'h60);
	endtask

	initial
	begin
		logic [7:0]  b;
		logic [31:0] v;
		void'($urandom(32'h3b5463c1));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		check("idle pins", {ser0, ser1, gp0, gp1, oe0, oe1}, 6'b111100);
		for (int c = 0; c < 2; c++)
		begin
			rd_chk("line rst", c[0], dup_pkg::REG_LINE, dup_pkg::LINE_RST);
			rd_chk("modem rst", c[0], dup_pkg::REG_MODEM, dup_pkg::MODEM_RST);
			rd_chk("div lo", c[0], dup_pkg::REG_DIV_LO, dup_pkg::DIV_RST[7:0]);
			rd_chk("div hi", c[0], dup_pkg::REG_DIV_HI, dup_pkg::DIV_RST[15:8]);
			rd_chk("stat rst", c[0], dup_pkg::REG_STATUS, 8'h60);
		end
		b = 8'($urandom);
		wr(1'b0, dup_pkg::REG_SCRATCH, b);
		wr(1'b1, dup_pkg::REG_SCRATCH, ~b);
		rd_chk("scratch0", 1'b0, dup_pkg::REG_SCRATCH, b);
		rd_chk("scratch1", 1'b1, dup_pkg::REG_SCRATCH, ~b);
		{ri_n, cd_n, dsr_n, cts_n} <= 8'($urandom);
		@(posedge clk);
		for (int c = 0; c < 2; c++)
			rd_chk("modem in", c[0], dup_pkg::REG_MSTAT,
				{4'h0, ~cd_n[c], ~ri_n[c], ~dsr_n[c], ~cts_n[c]});
		for (int c = 0; c < 2; c++)
		begin
			wr(c[0], dup_pkg::REG_MODEM, 8'h08);
			check("gp set", {gp0, gp1, oe0, oe1}, c ? 4'b1001 : 4'b0110);
			wr(c[0], dup_pkg::REG_MODEM, 8'h00);
			check("gp clr", {gp0, gp1, oe0, oe1}, 4'b1100);
			wr(c[0], dup_pkg::REG_DIV_LO, DIV);
			wr(c[0], dup_pkg::REG_DIV_HI, 8'h00);
		end
		// Every length with every parity mode, both directions
		for (int len = 5; len <= 8; len++)
			for (int p = 0; p < 3; p++)
			begin
				b = {3'h0, 1'(p == 2), 1'(p != 0), 1'b0, 2'(len - 5)};
				wr(1'b0, dup_pkg::REG_LINE, b);
				wr(1'b1, dup_pkg::REG_LINE, b);
				xfer(1'b0, len, p, 8'($urandom) | 8'h01);
				xfer(1'b1, len, p, 8'($urandom) | 8'h01);
			end
		// Loopback with the interrupt driven; the pin must stay idle
		wr(1'b0, dup_pkg::REG_MODEM, 8'h18);
		b = 8'($urandom);
		wr(1'b0, dup_pkg::REG_DATA, b);
		check("loop pin", ser0, 1'b1);
		wait_rx(1'b0);
		check("irq on", {irq0, oe0, gp0}, 3'b110);
		rd_chk("loop data", 1'b0, dup_pkg::REG_DATA, b);
		rd_chk("peer quiet", 1'b1, dup_pkg::REG_STATUS, 8'h60);
		check("irq off", irq0, 1'b0);
		apb(1'b0, 12'h008, 32'h0, v);
		check("unmapped", v, 32'h0);
		check("pslverr", pslverr, 1'b0);
		end_of_test();
	end
endmodule
